// ---- rtl/ics_sequencer.sv ----
// Purpose: channel sequencing and result registers of the converter
// Assumes: converter core reports one measurement per meas.valid pulse
// Notes: register requests arrive already decoded, on the same clock
`timescale 1ns/100ps
module ics_sequencer
#(
	parameter int NUM_CH = 4
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire ics_pkg::ics_req_s req,
	input wire ics_pkg::ics_meas_s meas,
	input wire logic ready_clear,
	output logic [15:0] rdata,
	output logic rvalid,
	output logic [3:0] chan_active,
	output logic conv_start,
	output logic result_ready_flag,
	output logic interrupt_out_n
);
	import ics_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_s1_r;
	logic rst_s2_r;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire rst_n = rst_s2_r;

	////////////////////////////////////////////////////////////////////
	// Functions
	// Last channel index of the scan list, limited by the variant
	function automatic logic [1:0] last_chan(input logic [1:0] list);
		logic [1:0] l;
		l = 2'h1;
		case (list)
			ICS_LIST_3CH: l = 2'h2;
			ICS_LIST_4CH: l = 2'h3;
			default: l = 2'h1;
		endcase
		if (NUM_CH < 4)
			l = 2'h1;
		return l;
	endfunction

	// Channel legal in this variant
	function automatic logic chan_ok(input logic [1:0] ch);
		return (NUM_CH >= 4) || (ch < 2'h2);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Registers and sequencing state
	typedef enum logic [1:0] {ICS_IDLE, ICS_START, ICS_CONV} ics_state_e;
	ics_state_e state_r, state_nxt;
	logic [15:0] cfg_r, cfg_nxt;
	logic [15:0] mux_r, mux_nxt;
	logic [11:0] res_r [4];
	logic [11:0] res_nxt [4];
	logic [1:0] cur_r, cur_nxt;
	logic [3:0] act_r, act_nxt;
	logic start_r, start_nxt;
	logic rdy_r, rdy_nxt;
	logic irq_n_r, irq_n_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;

	wire scan_en = mux_r[ICS_SCAN_BIT];
	wire [1:0] sel_ch = cfg_r[ICS_SEL_HI:ICS_SEL_LO];
	wire [1:0] list = mux_r[ICS_LIST_HI:ICS_LIST_LO];
	// single channel choice, legal in variant
	wire [1:0] first_ch = scan_en ? 2'h0 : (chan_ok(sel_ch) ? sel_ch : 2'h0);

	always_comb
	begin
		logic [11:0] code;
		code = 12'h000;
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		mux_nxt = mux_r;
		res_nxt = res_r;
		cur_nxt = cur_r;
		act_nxt = act_r;
		start_nxt = 1'b0;
		rdy_nxt = rdy_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		// Configuration writes
		if (req.wr && req.addr == ICS_OFF_CFG)
			cfg_nxt = req.wdata;
		if (req.wr && req.addr == ICS_OFF_MUX)
			mux_nxt = req.wdata;
		// Register reads
		if (req.rd)
		begin
			rvalid_nxt = 1'b1;
			case (req.addr)
				ICS_OFF_CH0: rdata_nxt = {4'h0, res_r[0]};
				ICS_OFF_CH1: rdata_nxt = {4'h0, res_r[1]};
				ICS_OFF_CH2: rdata_nxt = chan_ok(2'h2) ?
					{4'h0, res_r[2]} : 16'h0000;
				ICS_OFF_CH3: rdata_nxt = chan_ok(2'h3) ?
					{4'h0, res_r[3]} : 16'h0000;
				ICS_OFF_CFG: rdata_nxt = cfg_r;
				ICS_OFF_MUX: rdata_nxt = mux_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
		// ready flag, set wins over clear
		if (ready_clear)
			rdy_nxt = 1'b0;
		case (state_r)
			ICS_IDLE:
			begin
				cur_nxt = first_ch;
				state_nxt = ICS_START;
			end
			ICS_START:
			begin
				act_nxt = 4'h1 << cur_r;
				start_nxt = 1'b1;
				state_nxt = ICS_CONV;
			end
			ICS_CONV:
			begin
				if (meas.valid)
				begin
					code = meas.raw[ICS_RAW_W-1 -: ICS_RES_W];
					if (meas.under)
						code = ICS_UNDER;
					else if (meas.over)
						code = ICS_OVER;
					res_nxt[cur_r] = code;
					rdy_nxt = 1'b1;
					act_nxt = 4'h0;
					state_nxt = ICS_START;
					if (scan_en)
					begin
						if (cur_r >= last_chan(list))
							cur_nxt = 2'h0;
						else
							cur_nxt = cur_r + 2'h1;
					end
					else
						cur_nxt = first_ch;
				end
			end
			default: state_nxt = ICS_IDLE;
		endcase
	end

	assign irq_n_nxt = ~rdy_nxt;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ICS_IDLE;
			cfg_r <= ICS_CFG_RST;
			mux_r <= ICS_MUX_RST;
			for (int i = 0; i < 4; i++)
				res_r[i] <= 12'h000;
			cur_r <= 2'h0;
			act_r <= 4'h0;
			start_r <= 1'b0;
			rdy_r <= 1'b0;
			irq_n_r <= 1'b1;
			rdata_r <= 16'h0000;
			rvalid_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			mux_r <= mux_nxt;
			res_r <= res_nxt;
			cur_r <= cur_nxt;
			act_r <= act_nxt;
			start_r <= start_nxt;
			rdy_r <= rdy_nxt;
			irq_n_r <= irq_n_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign rdata = rdata_r;
	assign rvalid = rvalid_r;
	assign chan_active = act_r;
	assign conv_start = start_r;
	assign result_ready_flag = rdy_r;
	assign interrupt_out_n = irq_n_r;

	////////////////////////////////////////////////////////////////////
	// Assertions
	a_one_active: assert property (@(posedge clk) disable iff (!rst_n)
		$onehot0(chan_active))
		else $error("more than one channel active");

	a_single_chan: assert property (@(posedge clk) disable iff (!rst_n)
		(conv_start && !scan_en && chan_ok(sel_ch) && $stable(cfg_r)
		&& $stable(mux_r) && $past(state_r) == ICS_START
		&& $past(cur_r) == $past(first_ch)) |-> chan_active == (4'h1 << sel_ch))
		else $error("single mode on wrong channel");

	a_single_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == ICS_CONV && meas.valid && !scan_en)
		|=> cur_r == $past(first_ch))
		else $error("single mode left its channel");

	a_scan_step: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == ICS_CONV && meas.valid && scan_en
		&& cur_r < last_chan(list)) |=> cur_r == $past(cur_r) + 2'h1)
		else $error("scan did not advance");

	a_scan_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == ICS_CONV && meas.valid && scan_en
		&& cur_r >= last_chan(list)) |=> cur_r == 2'h0 ##1 conv_start
		&& chan_active == 4'h1)
		else $error("scan did not wrap to channel 0");

	a_list_bound: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == ICS_CONV && meas.valid && scan_en)
		|=> cur_r <= last_chan($past(list)))
		else $error("channel outside scan list");

	a_result_top: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == ICS_CONV && meas.valid && !meas.under && !meas.over)
		|=> res_r[$past(cur_r)] == $past(meas.raw[15:4]))
		else $error("result not top twelve bits");

	a_range_code: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == ICS_CONV && meas.valid && (meas.under || meas.over))
		|=> res_r[$past(cur_r)] == ($past(meas.under) ? ICS_UNDER : ICS_OVER))
		else $error("range code wrong");

	a_variant_lim: assert property (@(posedge clk) disable iff (!rst_n)
		(NUM_CH < 4) |-> chan_active[3:2] == 2'h0)
		else $error("absent channel active");

	a_ready_irq: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == ICS_CONV && meas.valid) |=> result_ready_flag
		&& !interrupt_out_n)
		else $error("ready flag or interrupt missing");
endmodule

// ---- include/ics_pkg.sv ----
// Purpose: shared constants and types for the inductive channel sequencer
// Assumes: 16-bit register words, 8-bit register addresses
// Notes: offsets are register addresses on the register port
package ics_pkg;
	localparam int ICS_DATA_W = 16;
	localparam int ICS_ADDR_W = 8;
	localparam int ICS_RES_W = 12;
	localparam int ICS_RAW_W = 16;
	localparam logic [7:0] ICS_OFF_CH0 = 8'h00;
	localparam logic [7:0] ICS_OFF_CH1 = 8'h02;
	localparam logic [7:0] ICS_OFF_CH2 = 8'h04;
	localparam logic [7:0] ICS_OFF_CH3 = 8'h06;
	localparam logic [7:0] ICS_OFF_CFG = 8'h1A;
	localparam logic [7:0] ICS_OFF_MUX = 8'h1B;
	localparam int ICS_SEL_HI = 15;
	localparam int ICS_SEL_LO = 14;
	localparam int ICS_SCAN_BIT = 15;
	localparam int ICS_LIST_HI = 14;
	localparam int ICS_LIST_LO = 13;
	localparam logic [15:0] ICS_CFG_RST = 16'h0000;
	localparam logic [15:0] ICS_MUX_RST = 16'h0000;
	localparam logic [1:0] ICS_LIST_2CH = 2'h0;
	localparam logic [1:0] ICS_LIST_3CH = 2'h1;
	localparam logic [1:0] ICS_LIST_4CH = 2'h2;
	localparam logic [11:0] ICS_UNDER = 12'h000;
	localparam logic [11:0] ICS_OVER = 12'hFFF;
	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} ics_req_s;
	// One finished measurement from the converter core
	typedef struct packed {
		logic valid;
		logic under;
		logic over;
		logic [15:0] raw;
	} ics_meas_s;
endpackage

// ---- dv/ics_core_model.sv ----
// Purpose: converter core model answering conversion starts
// Assumes: one conversion at a time, delay set by bench
// Notes: raw lines toggle while no result is offered
`timescale 1ns/100ps
module ics_core_model
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic conv_start,
	input wire logic [3:0] chan_active,
	input wire logic [7:0] delay,
	input wire logic under_in,
	input wire logic over_in,
	output ics_pkg::ics_meas_s meas
);
	import ics_pkg::*;
	logic busy_r;
	logic [7:0] cnt_r;
	logic [3:0] ch_r;
	logic [15:0] idx;
	assign idx = ch_r[3] ? 16'h0030 : ch_r[2] ? 16'h0020 :
		ch_r[1] ? 16'h0010 : 16'h0000;
	////////////////////////////////////////////////////////////////////////
	// result per channel
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy_r <= 1'b0;
			cnt_r <= 8'h00;
			ch_r <= 4'h0;
			meas <= '0;
		end
		else
		begin
			meas.valid <= 1'b0;
			meas.raw <= ~meas.raw;
			if (conv_start)
			begin
				busy_r <= 1'b1;
				cnt_r <= delay;
				ch_r <= chan_active;
			end
			else if (busy_r && cnt_r == 8'h00)
			begin
				busy_r <= 1'b0;
				meas <= {1'b1, under_in, over_in, 16'h5A30 + idx};
			end
			else if (busy_r)
				cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule

// ---- dv/ics_sequencer_test.sv ----
// Purpose: self-checking bench for the channel sequencer
// Assumes: core model answers each conversion start
// Notes: four-channel variant, with a two-channel instance checked alongside
`timescale 1ns/100ps
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module ics_sequencer_test;
	import ics_pkg::*;
	logic clk, reset_n, ready_clear, under_in, over_in, rvalid;
	logic conv_start, result_ready_flag, interrupt_out_n;
	logic [7:0] delay;
	logic [3:0] chan_active, ch;
	logic [15:0] rdata, d;
	logic [15:0] rdata_2ch;
	logic [3:0] act_2ch;
	ics_req_s req;
	ics_meas_s meas;
	int failures = 0;
	int checked = 0;
	ics_sequencer u_ics_sequencer (.clk(clk), .reset_n(reset_n),
		.req(req), .meas(meas), .ready_clear(ready_clear),
		.rdata(rdata), .rvalid(rvalid), .chan_active(chan_active),
		.conv_start(conv_start), .result_ready_flag(result_ready_flag),
		.interrupt_out_n(interrupt_out_n));
	ics_core_model u_ics_core_model (.clk(clk), .reset_n(reset_n),
		.conv_start(conv_start), .chan_active(chan_active),
		.delay(delay), .under_in(under_in), .over_in(over_in),
		.meas(meas));
	// Two-channel variant, runs in step with the main instance
	ics_sequencer #(.NUM_CH(2)) u_ics_sequencer_2ch (.clk(clk),
		.reset_n(reset_n), .req(req), .meas(meas),
		.ready_clear(ready_clear), .rdata(rdata_2ch), .rvalid(),
		.chan_active(act_2ch), .conv_start(), .result_ready_flag(),
		.interrupt_out_n());
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic report_and_stop;
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk) req.rd <= 1'b0;
		#1;
		`CHK("rvalid", 1'b1, rvalid)
		d = rdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk) req <= '{1'b1, 1'b0, a, v};
		@(posedge clk) req.wr <= 1'b0;
	endtask
	task automatic next_start;
		int i;
		for (i = 0; i < 300; i++)
		begin
			@(posedge clk);
			#1;
			if (conv_start === 1'b1)
				break;
		end
		if (i == 300)
		begin
			failures++;
			report_and_stop;
		end
		ch = chan_active;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(ICS_OFF_MUX);
		`CHK("irq_n", 1'b1, interrupt_out_n)
		`CHK("mux", ICS_MUX_RST, d)
		rd(8'h10);
		`CHK("unmapped", 16'h0000, d)
	endtask
	task automatic t_single;
		wr(ICS_OFF_CFG, 16'h8000);
		repeat (2) next_start;
		repeat (3)
		begin
			next_start;
			`CHK("single ch", 4'h4, ch)
			`CHK("two-ch single", 4'h1, act_2ch)
		end
		rd(ICS_OFF_CH2);
		`CHK("ch2 result", {4'h0, 12'h5A3 + 12'h002}, d)
		`CHK("two-ch ch2", 16'h0000, rdata_2ch)
	endtask
	task automatic t_scan;
		logic [15:0] mux [4] = '{16'h8000, 16'hA000, 16'hC000, 16'hE000};
		int n [4] = '{2, 3, 4, 2};
		delay <= 8'h01;
		for (int k = 0; k < 4; k++)
		begin
			wr(ICS_OFF_MUX, mux[k]);
			for (int i = 0; i < 10 && ch !== 4'h1; i++)
				next_start;
			for (int j = 1; j < 2 * n[k]; j++)
			begin
				next_start;
				`CHK("scan ch", 4'h1 << (j % n[k]), ch)
				`CHK("two-ch lim", 2'h0, act_2ch[3:2])
			end
		end
		wr(ICS_OFF_MUX, 16'h0000);
		delay <= 8'h14;
	endtask
	task automatic t_range;
		wr(ICS_OFF_CFG, 16'h0000);
		for (int k = 0; k < 3; k++)
		begin
			under_in <= (k != 1);
			over_in <= (k != 0);
			repeat (3) next_start;
			rd(ICS_OFF_CH0);
			`CHK("range", (k == 1) ? 16'h0FFF : 16'h0000, d)
		end
		under_in <= 1'b0;
		over_in <= 1'b0;
	endtask
	task automatic t_flag;
		next_start;
		@(posedge clk) ready_clear <= 1'b1;
		@(posedge clk) ready_clear <= 1'b0;
		#1;
		`CHK("flag clr", 1'b0, result_ready_flag)
		next_start;
		`CHK("flag set", 1'b1, result_ready_flag)
		`CHK("irq_n", 1'b0, interrupt_out_n)
	endtask
	initial
	begin
		reset_n = 1'b0;
		ready_clear = 1'b0;
		under_in = 1'b0;
		over_in = 1'b0;
		delay = 8'h14;
		req = '0;
		ch = 4'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		t_reset;
		t_single;
		t_scan;
		t_range;
		t_flag;
		report_and_stop;
	end
endmodule
